/* File: core/pdc_cfg.svh */
/*
 Offsets, field positions, reset values and cycle counts of the
 peripheral DMA channel. Assumes inclusion by bare name.
*/
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH
`define PDC_OFF_CNTP 8'h00
`define PDC_OFF_CTRL 8'h04
`define PDC_OFF_ADRP 8'h08
`define PDC_OFF_MODE 8'h0C
`define PDC_RST_PTR 8'h00
`define PDC_RST_CTRL 6'h07
`define PDC_IP_BIT 5
`define PDC_DM_BIT 4
`define PDC_IM_BIT 3
`define PDC_SEL_BIT 0
`define PDC_SWAP_BIT 0
`define PDC_TBL_BIT 1
`define PDC_EOB_BIT 2
`define PDC_BUSY_BIT 3
`define PDC_RF_CYC 5'h08
`define PDC_RF_WFI_CYC 5'h0A
`define PDC_MEM_CYC 5'h10
`define PDC_MEM_WFI_CYC 5'h12
`define PDC_WFI_SAMPLE 5
`define PDC_TBL_STEP 8'h02
`endif

/* File: core/pdc_pkg.sv */
/*
 Types of the peripheral DMA channel: engine states, target spaces
 and the descriptor/data access request. No surroundings assumed.
*/
package pdc_pkg;
  typedef enum logic [2:0] {
    PDC_IDLE  = 3'b001,
    PDC_ARMED = 3'b010,
    PDC_RUN   = 3'b100
  } pdc_state_e;
  typedef enum logic [1:0] {
    PDC_SP_RF   = 2'h0,
    PDC_SP_PROG = 2'h1,
    PDC_SP_DATA = 2'h2
  } pdc_space_e;
  typedef struct packed {
    logic req;
    logic we;
    pdc_space_e space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pdc_mem_req_s;
endpackage

/* File: core/pdc_channel.sv */
/*
 One peripheral DMA channel with APB register access.
 Assumes: a single clock pclk serving as both core and peripheral
 clock; the core gives a sampling pulse and an end-of-instruction
 pulse; the shared memory port answers a read one cycle after the
 request shows on mem_o.
*/
// Function
// - Up to 256 register-file or 65536 memory transactions a block.
// - Requests use the 8 interrupt levels, run at instruction end.
// - Same-level contest: transfer beats the interrupt.
// - Transfer needs level at or above current; interrupt strictly.
// - Transfer keeps the service level and cannot be interrupted.
// - Move one datum, bump address up, count down.
// - Register-file mode: address even register, count next odd.
// - Memory mode: 16-bit count pair and 16-bit address pair.
// - Memory mode space flag: 0 program, 1 data memory.
// - Request raised while pending flag and request mask are set.
// - Count reaching zero clears mask, raises end-of-block request.
// - No transfer acknowledged during top-level service.
// - Sample at core pulse, or every 5 cycles when waiting.
// - Register-file transfer: 8 cycles, 10 while waiting.
// - Memory transfer: 16 cycles, 18 while waiting.
// - Swap mode: alternate tables, keep mask, still raise request.
// - Alternation continues while swap mode stays on.
// - Pending set by trigger, cleared on acknowledge, software too.
// - Mask at zero: trigger yields no transfer request.
// - Priority 0 highest; 7 blocks interrupts, not transfers.
// - Pointer bits 7..1 locate the descriptors.
// - Direction fixed by the peripheral, not by a control bit.
// - End-of-block request reaches core only with global enable.
`timescale 1ns/1ps
`include "pdc_cfg.svh"
module pdc_channel #(
  parameter int WFI_DIV = `PDC_WFI_SAMPLE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core arbitration
  input wire logic [2:0] cur_lvl,
  input wire logic glb_ien,
  input wire logic tl_active,
  input wire logic wfi_active,
  input wire logic sample_pulse,
  input wire logic instr_end,
  input wire logic irq_vld,
  input wire logic [2:0] irq_lvl,
  input wire logic eob_ack,
  output logic dma_req,
  output logic dma_busy,
  output logic irq_ok,
  output logic eob_irq_req,
  // Peripheral side
  input wire logic trig,
  input wire logic to_periph,
  input wire logic [7:0] pdata_in,
  output logic [7:0] pdata_out,
  output logic pdata_wr,
  // Register file and memory port
  output pdc_pkg::pdc_mem_req_s mem_o,
  input wire logic [7:0] mem_rdata
);

  if (WFI_DIV < 2 || WFI_DIV > 8) begin : g_chk
    $error("WFI_DIV must be 2..8");
  end

  localparam logic [2:0] DIV_LAST = 3'(WFI_DIV - 1);

  ////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] cntp_ff, nxt_cntp, adrp_ff, nxt_adrp;
  logic ip_ff, nxt_ip, dm_ff, nxt_dm, im_ff, nxt_im;
  logic [2:0] prl_ff, nxt_prl;
  logic swap_ff, nxt_swap, tbl_ff, nxt_tbl, eob_ff, nxt_eob;
  logic [31:0] prd_ff, nxt_prd;
  pdc_pkg::pdc_state_e st_ff, nxt_st;
  logic [4:0] cyc_ff, nxt_cyc, last_cyc;
  logic [15:0] cnt_ff, nxt_cnt, adr_ff, nxt_adr;
  logic [7:0] pdo_ff, nxt_pdo;
  logic pwr_ff, nxt_pwr, rf_ff, nxt_rf, wfi_ff, nxt_wfi;
  logic [2:0] div_ff, nxt_div;
  pdc_pkg::pdc_mem_req_s mem_ff, nxt_mem;

  logic wr_en, hit, samp, dma_elig, ack, eob_ev;
  logic [7:0] cb, ab;
  logic [15:0] cnt_dec, adr_inc;

  ////////////////////////////////////////////////////////////////////
  // Arbitration and request outputs
  assign wr_en = psel & penable & pwrite;
  assign hit = paddr == `PDC_OFF_CNTP || paddr == `PDC_OFF_CTRL ||
               paddr == `PDC_OFF_ADRP || paddr == `PDC_OFF_MODE;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prd_ff;

  assign samp = wfi_active ? (div_ff == DIV_LAST) : sample_pulse;
  assign dma_req = ip_ff & dm_ff;
  // Lower number is higher priority; equal level still qualifies
  assign dma_elig = dma_req && prl_ff <= cur_lvl && !tl_active;
  assign dma_busy = st_ff != pdc_pkg::PDC_IDLE;
  // Other interrupts held off while a transfer is armed or running
  assign irq_ok = irq_vld && glb_ien && !tl_active && !dma_busy &&
                  irq_lvl < cur_lvl &&
                  !(dma_elig && prl_ff <= irq_lvl);
  assign eob_irq_req = eob_ff && im_ff && glb_ien && !tl_active &&
                       prl_ff < cur_lvl;
  assign pdata_out = pdo_ff;
  assign pdata_wr = pwr_ff;
  assign mem_o = mem_ff;

  ////////////////////////////////////////////////////////////////////
  // Descriptor addressing
  // Table 1 sits one even pair above table 0
  assign cb = {cntp_ff[7:1], 1'b0} + (tbl_ff ? `PDC_TBL_STEP : 8'h00);
  assign ab = {adrp_ff[7:1], 1'b0} + (tbl_ff ? `PDC_TBL_STEP : 8'h00);
  assign cnt_dec = cnt_ff - 16'h0001;
  assign adr_inc = adr_ff + 16'h0001;

  always_comb begin
    if (rf_ff) begin
      last_cyc = wfi_ff ? `PDC_RF_WFI_CYC - 5'h01 :
                          `PDC_RF_CYC - 5'h01;
    end else begin
      last_cyc = wfi_ff ? `PDC_MEM_WFI_CYC - 5'h01 :
                          `PDC_MEM_CYC - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transfer engine
  always_comb begin
    nxt_st = st_ff;
    nxt_cyc = cyc_ff;
    nxt_cnt = cnt_ff;
    nxt_adr = adr_ff;
    nxt_pdo = pdo_ff;
    nxt_pwr = 1'b0;
    nxt_rf = rf_ff;
    nxt_wfi = wfi_ff;
    nxt_mem = '0;
    nxt_mem.space = pdc_pkg::PDC_SP_RF;
    ack = 1'b0;
    eob_ev = 1'b0;
    nxt_div = (wfi_active && div_ff != DIV_LAST) ? div_ff + 3'h1 : 3'h0;
    case (st_ff)
      pdc_pkg::PDC_IDLE: begin
        if (samp && dma_elig) begin
          ack = 1'b1;
          nxt_st = pdc_pkg::PDC_ARMED;
        end
      end
      pdc_pkg::PDC_ARMED: begin
        if (instr_end || wfi_active) begin
          nxt_st = pdc_pkg::PDC_RUN;
          nxt_cyc = 5'h00;
          nxt_rf = cntp_ff[`PDC_SEL_BIT];
          nxt_wfi = wfi_active;
        end
      end
      pdc_pkg::PDC_RUN: begin
        nxt_cyc = cyc_ff + 5'h01;
        if (cyc_ff == last_cyc) begin
          nxt_st = pdc_pkg::PDC_IDLE;
        end
        nxt_mem.req = 1'b1;
        if (rf_ff) begin
          // Address at even location, count at the odd one after
          case (cyc_ff)
            5'h00: nxt_mem.addr = {8'h00, cb + 8'h01};
            5'h01: nxt_mem.addr = {8'h00, cb};
            5'h02: nxt_cnt = {8'h00, mem_rdata};
            5'h03: nxt_adr = {8'h00, mem_rdata};
            5'h04: begin
              nxt_mem.addr = {8'h00, adr_ff[7:0]};
              nxt_mem.we = ~to_periph;
              nxt_mem.wdata = pdata_in;
            end
            5'h05: begin
              nxt_mem.addr = {8'h00, cb};
              nxt_mem.we = 1'b1;
              nxt_mem.wdata = adr_inc[7:0];
            end
            5'h06: begin
              nxt_mem.addr = {8'h00, cb + 8'h01};
              nxt_mem.we = 1'b1;
              nxt_mem.wdata = cnt_dec[7:0];
              eob_ev = cnt_dec[7:0] == 8'h00;
              nxt_pdo = to_periph ? mem_rdata : pdo_ff;
              nxt_pwr = to_periph;
            end
            default: nxt_mem.req = 1'b0;
          endcase
        end else begin
          // Pairs: high byte even, low byte odd
          case (cyc_ff)
            5'h00: nxt_mem.addr = {8'h00, cb};
            5'h01: nxt_mem.addr = {8'h00, cb + 8'h01};
            5'h02: begin
              nxt_mem.addr = {8'h00, ab};
              nxt_cnt[15:8] = mem_rdata;
            end
            5'h03: begin
              nxt_mem.addr = {8'h00, ab + 8'h01};
              nxt_cnt[7:0] = mem_rdata;
            end
            5'h04: begin
              nxt_mem.req = 1'b0;
              nxt_adr[15:8] = mem_rdata;
            end
            5'h05: begin
              nxt_mem.req = 1'b0;
              nxt_adr[7:0] = mem_rdata;
            end
            5'h06: begin
              nxt_mem.space = adrp_ff[`PDC_SEL_BIT] ?
                pdc_pkg::PDC_SP_DATA : pdc_pkg::PDC_SP_PROG;
              nxt_mem.addr = adr_ff;
              nxt_mem.we = ~to_periph;
              nxt_mem.wdata = pdata_in;
            end
            5'h07: begin
              nxt_mem.addr = {8'h00, ab};
              nxt_mem.we = 1'b1;
              nxt_mem.wdata = adr_inc[15:8];
            end
            5'h08: begin
              nxt_mem.addr = {8'h00, ab + 8'h01};
              nxt_mem.we = 1'b1;
              nxt_mem.wdata = adr_inc[7:0];
              nxt_pdo = to_periph ? mem_rdata : pdo_ff;
              nxt_pwr = to_periph;
            end
            5'h09: begin
              nxt_mem.addr = {8'h00, cb};
              nxt_mem.we = 1'b1;
              nxt_mem.wdata = cnt_dec[15:8];
            end
            5'h0A: begin
              nxt_mem.addr = {8'h00, cb + 8'h01};
              nxt_mem.we = 1'b1;
              nxt_mem.wdata = cnt_dec[7:0];
              eob_ev = cnt_dec == 16'h0000;
            end
            default: nxt_mem.req = 1'b0;
          endcase
        end
      end
      default: nxt_st = pdc_pkg::PDC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= pdc_pkg::PDC_IDLE;
      cyc_ff <= 5'h00;
      cnt_ff <= 16'h0000;
      adr_ff <= 16'h0000;
      pdo_ff <= 8'h00;
      pwr_ff <= 1'b0;
      rf_ff <= 1'b0;
      wfi_ff <= 1'b0;
      div_ff <= 3'h0;
      mem_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cyc_ff <= nxt_cyc;
      cnt_ff <= nxt_cnt;
      adr_ff <= nxt_adr;
      pdo_ff <= nxt_pdo;
      pwr_ff <= nxt_pwr;
      rf_ff <= nxt_rf;
      wfi_ff <= nxt_wfi;
      div_ff <= nxt_div;
      mem_ff <= nxt_mem;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers
  always_comb begin
    nxt_cntp = cntp_ff;
    nxt_adrp = adrp_ff;
    nxt_ip = ip_ff;
    nxt_dm = dm_ff;
    nxt_im = im_ff;
    nxt_prl = prl_ff;
    nxt_swap = swap_ff;
    nxt_tbl = tbl_ff;
    nxt_eob = eob_ff;
    nxt_prd = prd_ff;
    if (ack) begin
      nxt_ip = 1'b0;
    end
    if (eob_ev && !swap_ff) begin
      nxt_dm = 1'b0;
    end
    if (eob_ev && swap_ff) begin
      nxt_tbl = ~tbl_ff;
    end
    if (eob_ack) begin
      nxt_eob = 1'b0;
    end
    if (wr_en) begin
      case (paddr)
        `PDC_OFF_CNTP: nxt_cntp = pwdata[7:0];
        `PDC_OFF_ADRP: nxt_adrp = pwdata[7:0];
        `PDC_OFF_CTRL: begin
          nxt_ip = pwdata[`PDC_IP_BIT];
          nxt_dm = pwdata[`PDC_DM_BIT];
          nxt_im = pwdata[`PDC_IM_BIT];
          nxt_prl = pwdata[2:0];
        end
        `PDC_OFF_MODE: begin
          nxt_swap = pwdata[`PDC_SWAP_BIT];
          if (!pwdata[`PDC_SWAP_BIT]) begin
            nxt_tbl = 1'b0;
          end
          if (pwdata[`PDC_EOB_BIT]) begin
            nxt_eob = 1'b0;
          end
        end
        default: nxt_ip = nxt_ip;
      endcase
    end
    // Hardware sets win over any clear in the same cycle
    if (trig) begin
      nxt_ip = 1'b1;
    end
    if (eob_ev) begin
      nxt_eob = 1'b1;
    end
    if (psel && !penable) begin
      case (paddr)
        `PDC_OFF_CNTP: nxt_prd = {24'h000000, cntp_ff};
        `PDC_OFF_ADRP: nxt_prd = {24'h000000, adrp_ff};
        `PDC_OFF_CTRL: nxt_prd = {26'h0000000, ip_ff, dm_ff, im_ff,
                                  prl_ff};
        `PDC_OFF_MODE: nxt_prd = {28'h0000000, dma_busy, eob_ff,
                                  tbl_ff, swap_ff};
        default: nxt_prd = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cntp_ff <= `PDC_RST_PTR;
      adrp_ff <= `PDC_RST_PTR;
      {ip_ff, dm_ff, im_ff, prl_ff} <= `PDC_RST_CTRL;
      swap_ff <= 1'b0;
      tbl_ff <= 1'b0;
      eob_ff <= 1'b0;
      prd_ff <= 32'h00000000;
    end else begin
      cntp_ff <= nxt_cntp;
      adrp_ff <= nxt_adrp;
      ip_ff <= nxt_ip;
      dm_ff <= nxt_dm;
      im_ff <= nxt_im;
      prl_ff <= nxt_prl;
      swap_ff <= nxt_swap;
      tbl_ff <= nxt_tbl;
      eob_ff <= nxt_eob;
      prd_ff <= nxt_prd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb_chk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ip_set_a: assert property (trig |=> ip_ff)
    else $error("trigger did not set pending");
  arm_level_a: assert property (
    $rose(st_ff == pdc_pkg::PDC_ARMED) |->
      $past(prl_ff) <= $past(cur_lvl) && !$past(tl_active) &&
      $past(dm_ff))
    else $error("transfer armed against priority");
  rf_len_a: assert property (
    st_ff == pdc_pkg::PDC_RUN && cyc_ff == 5'h00 && rf_ff && !wfi_ff
    |-> (st_ff == pdc_pkg::PDC_RUN)[*8] ##1
        st_ff == pdc_pkg::PDC_IDLE)
    else $error("register file transfer length wrong");
  mem_len_a: assert property (
    $fell(st_ff == pdc_pkg::PDC_RUN) && !rf_ff |->
      $past(cyc_ff) == (wfi_ff ? 5'h11 : 5'h0F))
    else $error("memory transfer length wrong");
  eob_mask_a: assert property (
    eob_ev && !swap_ff && !(wr_en && paddr == `PDC_OFF_CTRL)
    |=> !dm_ff && eob_ff)
    else $error("end of block did not clear mask");
  swap_tbl_a: assert property (
    eob_ev && swap_ff && !wr_en |=>
      tbl_ff != $past(tbl_ff) && dm_ff == $past(dm_ff))
    else $error("swap did not alternate tables");
  run_block_a: assert property (dma_busy |-> !irq_ok)
    else $error("interrupt allowed during transfer");
  same_lvl_a: assert property (
    dma_elig && irq_vld && irq_lvl == prl_ff |-> !irq_ok)
    else $error("interrupt beat same level transfer");
  eob_gate_a: assert property (
    eob_irq_req |-> glb_ien && im_ff && prl_ff != 3'h7)
    else $error("end of block request ungated");
  desc_even_a: assert property (
    st_ff == pdc_pkg::PDC_RUN && cyc_ff == 5'h01 && !rf_ff
    |-> mem_o.req && !mem_o.addr[0])
    else $error("descriptor address not even");

  rf_done_c: cover property (eob_ev && rf_ff);
  mem_wfi_c: cover property ($fell(st_ff == pdc_pkg::PDC_RUN) &&
                             !rf_ff && wfi_ff);
  swap_c: cover property (eob_ev && swap_ff);
  contest_c: cover property (dma_elig && irq_vld && irq_lvl == prl_ff);

endmodule

/* File: tb/pdc_mem_model.sv */
/*
 Register file, program and data memory behind the channel.
 Assumes one clock; a read answers in the cycle after the request.
*/
`timescale 1ns/1ps
module pdc_mem_model (
  // Clock
  input wire logic pclk,
  // Access port of the channel
  input wire pdc_pkg::pdc_mem_req_s mem_i,
  output logic [7:0] mem_rdata
);
  // Keyed by space and address, so the spaces never alias
  logic [7:0] store [int];
  initial mem_rdata = 8'h00;
  always @(posedge pclk) begin
    if (mem_i.req === 1'h1 && mem_i.we === 1'h1) begin
      store[int'({mem_i.space, mem_i.addr})] = mem_i.wdata;
    end
    if (mem_i.req === 1'h1 && mem_i.we === 1'h0) begin
      mem_rdata <= store[int'({mem_i.space, mem_i.addr})];
    end else begin
      // Inverted stale data, so a late sample cannot pass
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* File: tb/tb_top.sv */
/*
 Bench of the DMA channel: APB tasks, core pulses, memory model.
 Assumes the package, the header and the memory model are compiled.
*/
`timescale 1ns/1ps
`include "pdc_cfg.svh"
module tb_top;
  localparam logic [7:0] CNT = `PDC_OFF_CNTP;
  localparam logic [7:0] CTL = `PDC_OFF_CTRL;
  localparam logic [7:0] ADR = `PDC_OFF_ADRP;
  localparam logic [7:0] MOD = `PDC_OFF_MODE;
  localparam pdc_pkg::pdc_space_e SP_R = pdc_pkg::PDC_SP_RF;
  localparam pdc_pkg::pdc_space_e SP_P = pdc_pkg::PDC_SP_PROG;
  localparam pdc_pkg::pdc_space_e SP_D = pdc_pkg::PDC_SP_DATA;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, pdata_in = 8'hA5;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [2:0] cur_lvl = 3'h3, irq_lvl = 3'h0;
  logic glb_ien = 1'h1, tl_active = 1'h0, wfi_active = 1'h0;
  logic sample_pulse = 1'h0, instr_end = 1'h0, irq_vld = 1'h1;
  logic eob_ack = 1'h0, trig = 1'h0, to_periph = 1'h0, e;
  logic pready, pslverr, dma_req, dma_busy, irq_ok, eob_irq_req;
  logic pdata_wr, busy_irq_ok = 1'h0;
  logic [7:0] pdata_out, mem_rdata, wr_seen = 8'h00;
  pdc_pkg::pdc_mem_req_s mem_o;
  int mismatches = 0, samples_checked = 0, cycles = 0, hi, wt;

  always #25 pclk = ~pclk;

  pdc_channel #(.WFI_DIV(5)) u_pdc_channel (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cur_lvl(cur_lvl),
    .glb_ien(glb_ien), .tl_active(tl_active), .wfi_active(wfi_active),
    .sample_pulse(sample_pulse), .instr_end(instr_end),
    .irq_vld(irq_vld), .irq_lvl(irq_lvl), .eob_ack(eob_ack),
    .dma_req(dma_req), .dma_busy(dma_busy), .irq_ok(irq_ok),
    .eob_irq_req(eob_irq_req), .trig(trig), .to_periph(to_periph),
    .pdata_in(pdata_in), .pdata_out(pdata_out), .pdata_wr(pdata_wr),
    .mem_o(mem_o), .mem_rdata(mem_rdata)
  );
  pdc_mem_model u_pdc_mem_model (
    .pclk(pclk), .mem_i(mem_o), .mem_rdata(mem_rdata)
  );

  always @(negedge pclk) begin
    if (pdata_wr === 1'h1) wr_seen <= pdata_out;
    if (dma_busy === 1'h1 && irq_ok !== 1'h0) busy_irq_ok <= 1'h1;
  end
  // Runaway guard, well above the few hundred cycles needed
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  function automatic int key(input pdc_pkg::pdc_space_e sp,
                             input logic [15:0] a);
    return int'({sp, a});
  endfunction
  task automatic poke(input pdc_pkg::pdc_space_e sp,
                      input logic [15:0] a, input logic [7:0] v);
    u_pdc_mem_model.store[key(sp, a)] = v;
  endtask
  task automatic chkm(input pdc_pkg::pdc_space_e sp,
                      input logic [15:0] a, input logic [7:0] x);
    chk("memory", {24'h0, u_pdc_mem_model.store[key(sp, a)]}, {24'h0, x});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Wait states are the slave's business; only the runaway guard ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk("register", q, x);
  endtask
  task automatic trig_pulse();
    @(posedge pclk);
    trig <= 1'h1;
    @(posedge pclk);
    trig <= 1'h0;
    @(negedge pclk);
  endtask
  // One sampling point; hi gets the cycles that busy stood high,
  // wt the cycles waited before it rose
  task automatic xfer(input logic wfi);
    int n;
    n = 0;
    @(posedge pclk);
    wfi_active <= wfi;
    sample_pulse <= !wfi;
    @(posedge pclk);
    sample_pulse <= 1'h0;
    while (dma_busy !== 1'h1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    wt = n;
    hi = 0;
    for (int k = 0; k < 40 && dma_busy === 1'h1; k++) begin
      hi++;
      @(posedge pclk);
      instr_end <= (k == 0) && !wfi;
      @(negedge pclk);
    end
    @(posedge pclk);
    wfi_active <= 1'h0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    rd(CNT, 32'h00);
    rd(CTL, 32'h07);
    rd(MOD, 32'h00);
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("pready", pready, 1'h1);
    wr(CTL, 32'hFF);
    rd(CTL, 32'h3F);
    chk("irq_ok", irq_ok, 1'h1);
    $display("test registers done");
    wr(CNT, 32'h21);
    poke(SP_R, 16'h20, 8'h40);
    poke(SP_R, 16'h21, 8'h02);
    wr(CTL, 32'h0B);
    trig_pulse();
    rd(CTL, 32'h2B);
    chk("dma_req", dma_req, 1'h0);
    wr(CTL, 32'h1B);
    trig_pulse();
    chk("dma_req", dma_req, 1'h1);
    wr(CTL, 32'h1B);
    chk("dma_req", dma_req, 1'h0);
    wr(CTL, 32'h3B);
    chk("dma_req", dma_req, 1'h1);
    @(posedge pclk);
    cur_lvl <= 3'h2;
    xfer(1'h0);
    chk("busy", hi, 0);
    @(posedge pclk);
    cur_lvl <= 3'h3;
    tl_active <= 1'h1;
    xfer(1'h0);
    chk("busy", hi, 0);
    @(posedge pclk);
    tl_active <= 1'h0;
    cur_lvl <= 3'h4;
    irq_lvl <= 3'h3;
    @(negedge pclk);
    chk("irq_ok", irq_ok, 1'h0);
    @(posedge pclk);
    irq_lvl <= 3'h2;
    @(negedge pclk);
    chk("irq_ok", irq_ok, 1'h1);
    @(posedge pclk);
    cur_lvl <= 3'h3;
    irq_lvl <= 3'h0;
    $display("test gating done");
    xfer(1'h0);
    chk("busy", hi, `PDC_RF_CYC + 2);
    chkm(SP_R, 16'h40, 8'hA5);
    chkm(SP_R, 16'h20, 8'h41);
    chkm(SP_R, 16'h21, 8'h01);
    rd(CTL, 32'h1B);
    wr(CTL, 32'h3B);
    xfer(1'h1);
    chk("busy", hi, `PDC_RF_WFI_CYC + 1);
    chk("wfi wait", wt, `PDC_WFI_SAMPLE);
    chkm(SP_R, 16'h41, 8'hA5);
    rd(CTL, 32'h0B);
    rd(MOD, 32'h04);
    chk("eob", eob_irq_req, 1'h0);
    @(posedge pclk);
    cur_lvl <= 3'h4;
    @(negedge pclk);
    chk("eob", eob_irq_req, 1'h1);
    @(posedge pclk);
    glb_ien <= 1'h0;
    @(negedge pclk);
    chk("eob", eob_irq_req, 1'h0);
    @(posedge pclk);
    glb_ien <= 1'h1;
    eob_ack <= 1'h1;
    @(posedge pclk);
    eob_ack <= 1'h0;
    rd(MOD, 32'h00);
    $display("test register file done");
    wr(CNT, 32'h30);
    wr(ADR, 32'h51);
    poke(SP_R, 16'h30, 8'h00);
    poke(SP_R, 16'h31, 8'h02);
    poke(SP_R, 16'h50, 8'h12);
    poke(SP_R, 16'h51, 8'hFF);
    poke(SP_D, 16'h12FF, 8'h5C);
    poke(SP_D, 16'h1300, 8'h5D);
    poke(SP_P, 16'h12FF, 8'hC3);
    @(posedge pclk);
    to_periph <= 1'h1;
    cur_lvl <= 3'h3;
    wr(CTL, 32'h3B);
    xfer(1'h0);
    chk("busy", hi, `PDC_MEM_CYC + 2);
    chk("datum", wr_seen, 8'h5C);
    chkm(SP_R, 16'h50, 8'h13);
    chkm(SP_R, 16'h51, 8'h00);
    chkm(SP_R, 16'h31, 8'h01);
    wr(CTL, 32'h3B);
    xfer(1'h1);
    chk("busy", hi, `PDC_MEM_WFI_CYC + 1);
    chk("datum", wr_seen, 8'h5D);
    rd(CTL, 32'h0B);
    $display("test memory done");
    wr(CNT, 32'h21);
    poke(SP_R, 16'h20, 8'h60);
    poke(SP_R, 16'h21, 8'h01);
    poke(SP_R, 16'h22, 8'h70);
    poke(SP_R, 16'h23, 8'h01);
    @(posedge pclk);
    to_periph <= 1'h0;
    cur_lvl <= 3'h7;
    pdata_in <= 8'h77;
    wr(MOD, 32'h05);
    wr(CTL, 32'h3F);
    xfer(1'h0);
    chk("busy", hi, `PDC_RF_CYC + 2);
    chkm(SP_R, 16'h60, 8'h77);
    rd(MOD, 32'h07);
    rd(CTL, 32'h1F);
    wr(CTL, 32'h3F);
    xfer(1'h0);
    chkm(SP_R, 16'h70, 8'h77);
    rd(MOD, 32'h05);
    chk("irq_ok", busy_irq_ok, 1'h0);
    $display("test swap done");
    test_done();
  end
endmodule
